/* File: sfm_defines.svh */
// Shared constants of the servo fault monitor: timing, limits, codes.
// Assumes a 40 MHz control clock; counts derive from the times below.
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH

// ============================================================
// Clock and measuring window
`define SFM_CLK_MHZ 40
`define SFM_WIN_NS 100000
`define SFM_WIN_CYC ((`SFM_WIN_NS * `SFM_CLK_MHZ) / 1000)
`define SFM_WIN_PER_S (1000000000 / `SFM_WIN_NS)

// ============================================================
// Command velocity limits
`define SFM_CMD_MAX_RPS 30
`define SFM_LIM_NUM 3
`define SFM_LIM_DEN 2
`define SFM_HOLD_NS 1000000
`define SFM_HOLD_WIN (`SFM_HOLD_NS / `SFM_WIN_NS)

// ============================================================
// Feedback output tolerance, percent of the highest output rate
`define SFM_FB_TOL_PCT 110

// ============================================================
// Commutation check
`define SFM_COMM_DEG 15
`define SFM_DEG_PER_REV 360
`define SFM_COMM_CHECK_NS 200000000
`define SFM_COMM_CHECK_CYC ((`SFM_COMM_CHECK_NS / 1000) * `SFM_CLK_MHZ)

// ============================================================
// Processor watchdog
`define SFM_WDT_NS 10000000
`define SFM_WDT_CYC ((`SFM_WDT_NS / 1000) * `SFM_CLK_MHZ)

// ============================================================
// Warning cause sub-codes, reset values, history depth and divider steps
`define SFM_SUB_CMD 2'h0
`define SFM_SUB_LIM 2'h1
`define SFM_SUB_FB 2'h2
`define SFM_VL_RST 16'h000A
`define SFM_HIST_DEPTH 8
`define SFM_DIV_STEPS 6'h20

`endif

/* File: sfm_pkg.sv */
// Types shared by the servo fault monitor modules.
// Needs sfm_defines.svh on the include path.
`include "sfm_defines.svh"
package sfm_pkg;
    typedef logic [47:0] sfm_wide_t;
    typedef logic [15:0] sfm_count_t;
    typedef enum logic [1:0] {
        CM_ARMED = 2'b00,
        CM_CHECK = 2'b01,
        CM_DONE = 2'b10
    } sfm_comm_e;
endpackage

/* File: sfm_rate_if.sv */
// Pulse rate link between the monitor and a rate meter.
// Pulses are one-cycle strobes in the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
interface sfm_rate_if;
    import sfm_pkg::*;
    logic pulse;
    logic tick;
    sfm_count_t count;
    modport meter (input pulse, output tick, output count);
    modport user (output pulse, input tick, input count);
endinterface
`default_nettype wire

/* File: sfm_rate_meter.sv */
// Counts pulses over a fixed window and publishes the total.
// Assumes at most one pulse per clock cycle.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_defines.svh"
module sfm_rate_meter import sfm_pkg::*; #(
    parameter int WIN_CYC = `SFM_WIN_CYC
) (
    input wire logic clk,
    input wire logic rstSync_b,
    sfm_rate_if.meter rate
);
    typedef struct packed {
        logic [15:0] winCnt;
        sfm_count_t acc;
        sfm_count_t count;
        logic tick;
    } sfm_meter_s;

    sfm_meter_s q, d;
    logic winEnd;

    assign winEnd = (q.winCnt == 16'(WIN_CYC - 1));

    always_comb begin
        d = q;
        d.tick = winEnd;
        if (winEnd) begin
            d.winCnt = 16'h0000;
            d.count = q.acc + {15'h0000, rate.pulse};
            d.acc = 16'h0000;
        end else begin
            d.winCnt = q.winCnt + 16'h0001;
            // Saturate so a runaway input never wraps to a small rate
            if (rate.pulse && (q.acc != 16'hFFFF)) begin
                d.acc = q.acc + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rate.tick = q.tick;
    assign rate.count = q.count;
endmodule // sfm_rate_meter
`default_nettype wire

/* File: sfm_cpu_watchdog.sv */
// Watches the control processor heartbeat, a level it toggles.
// Fault is latched until the next power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_defines.svh"
module sfm_cpu_watchdog import sfm_pkg::*; #(
    parameter int TIMEOUT_CYC = `SFM_WDT_CYC
) (
    input wire logic clk,
    input wire logic rstSync_b,
    input wire logic heartbeat,
    output logic fault
);
    typedef struct packed {
        logic prevBeat;
        logic [31:0] idleCnt;
        logic fault;
    } sfm_wdt_s;

    sfm_wdt_s q, d;

    always_comb begin
        d = q;
        d.prevBeat = heartbeat;
        if (heartbeat != q.prevBeat) begin
            d.idleCnt = 32'h0000_0000;
        end else if (q.idleCnt >= 32'(TIMEOUT_CYC - 1)) begin
            d.fault = 1'b1;
        end else begin
            d.idleCnt = q.idleCnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign fault = q.fault;
endmodule // sfm_cpu_watchdog
`default_nettype wire

/* File: servo_fault_monitor.sv */
// Fault monitor of a servo drive: commutation check, command and
// feedback warning with cause history, processor fault.
// Assumes all inputs synchronous to ref_clk; strobes last one cycle.
// Rate scaling assumes the default window; other lengths shift the limits.
// Commutation alarm and processor fault clear only at power-on reset.
//
// Contract
// - Commutation alarm if first activation moves >15 degrees
// - Warn on excessive command or abnormal feedback rate
// - Record warning cause sub-code in queryable history
// - Command velocity from pulses scaled by circular resolution
// - Feedback resolution write recomputes velocity limiter
// - Sub-code 0 when command exceeds 30 rev/s
// - Sub-code 1 above 1.5x limiter beyond 1 ms
// - Sub-code 2 when feedback output frequency out of tolerance
// - Actual velocity above limiter is a feedback fault
// - Clear input or clear command clears the warning
// - Processor fault alarm when control processor stalls
`timescale 1ns/1ps
`default_nettype none
`include "sfm_defines.svh"

module servo_fault_monitor import sfm_pkg::*; #(
    parameter int COMM_CHECK_CYC = `SFM_COMM_CHECK_CYC,
    parameter int WDT_CYC = `SFM_WDT_CYC,
    parameter int WIN_CYC = `SFM_WIN_CYC,
    parameter int DET_RES = 4096,
    parameter int FB_MAX_HZ = 1000000
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic servoOn,
    input wire logic [23:0] posCount,
    input wire logic cmdPulse,
    input wire logic fbOutPulse,
    input wire logic [23:0] circularResolution,
    input wire logic [23:0] feedbackResolution,
    input wire logic feedbackResolutionWrite,
    input wire logic alarmClearInput,
    input wire logic clearAlarmCommand,
    input wire logic alarmHistoryQuery,
    input wire logic [2:0] historyIndex,
    input wire logic cpuHeartbeat,
    output logic commutationAlarm,
    output logic commandFeedbackWarning,
    output logic [1:0] warningCause,
    output logic [15:0] velocityLimiter,
    output logic velocityLimiterBusy,
    output logic [1:0] historyCause,
    output logic historyHit,
    output logic historyValid,
    output logic processorFaultAlarm
);
    // ============================================================
    // Reset release
    logic [1:0] rstPipe_q;
    logic rstSync_b;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe_q <= 2'b00;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSync_b = rstPipe_q[1];

    // ============================================================
    // Rate meters and watchdog
    // Both rates share one window length so their ticks line up
    sfm_rate_if cmdRate ();
    sfm_rate_if fbRate ();
    assign cmdRate.pulse = cmdPulse;
    assign fbRate.pulse = fbOutPulse;

    sfm_rate_meter #(.WIN_CYC(WIN_CYC)) uCmdMeter (
        .clk(ref_clk),
        .rstSync_b(rstSync_b),
        .rate(cmdRate)
    );

    sfm_rate_meter #(.WIN_CYC(WIN_CYC)) uFbMeter (
        .clk(ref_clk),
        .rstSync_b(rstSync_b),
        .rate(fbRate)
    );

    sfm_cpu_watchdog #(.TIMEOUT_CYC(WDT_CYC)) uWatchdog (
        .clk(ref_clk),
        .rstSync_b(rstSync_b),
        .heartbeat(cpuHeartbeat),
        .fault(processorFaultAlarm)
    );

    // ============================================================
    // State
    typedef struct packed {
        sfm_comm_e comm;
        logic [23:0] commStart;
        logic [31:0] commCnt;
        logic commAlarm;
        logic [23:0] prevPos;
        logic [15:0] vl;
        logic divBusy;
        logic [5:0] divCnt;
        logic [24:0] divRem;
        logic [31:0] divQuo;
        logic [23:0] frHeld;
        logic [3:0] holdCnt;
        logic warn;
        logic [1:0] cause;
        logic [`SFM_HIST_DEPTH-1:0][1:0] hist;
        logic [2:0] histPtr;
        logic [3:0] histFill;
        logic [1:0] histOut;
        logic histHit;
        logic histValid;
    } sfm_state_s;

    sfm_state_s q, d;

    // Absolute value of a wrapped 24-bit position difference
    function automatic logic [23:0] absDiff(input logic [23:0] a, input logic [23:0] b);
        logic [23:0] diff;
        diff = a - b;
        return diff[23] ? (24'h000000 - diff) : diff;
    endfunction

    // ============================================================
    // Velocity comparisons in per-second units, plus the commutation angle, cross-multiplied to avoid division
    sfm_wide_t cmdScaled, cmdMaxScaled, cmdLimScaled, vlCmdScaled;
    sfm_wide_t fbScaled, fbTolScaled, actScaled, vlActScaled;
    sfm_wide_t commScaled, commLimScaled;
    logic overCmdMax, overCmdLim, overFbTol, overActVel, overComm;

    // Command rev/s = count * windows-per-second / CR
    assign cmdScaled = sfm_wide_t'(cmdRate.count) * sfm_wide_t'(`SFM_WIN_PER_S);
    assign cmdMaxScaled = sfm_wide_t'(`SFM_CMD_MAX_RPS) * sfm_wide_t'(circularResolution);
    assign overCmdMax = cmdScaled > cmdMaxScaled;
    assign cmdLimScaled = cmdScaled * sfm_wide_t'(`SFM_LIM_DEN);
    assign vlCmdScaled = sfm_wide_t'(`SFM_LIM_NUM) * sfm_wide_t'(q.vl)
        * sfm_wide_t'(circularResolution);
    assign overCmdLim = cmdLimScaled > vlCmdScaled;

    assign fbScaled = sfm_wide_t'(fbRate.count) * sfm_wide_t'(`SFM_WIN_PER_S) * sfm_wide_t'(100);
    assign fbTolScaled = sfm_wide_t'(FB_MAX_HZ) * sfm_wide_t'(`SFM_FB_TOL_PCT);
    assign overFbTol = fbScaled > fbTolScaled;

    assign actScaled = sfm_wide_t'(absDiff(posCount, q.prevPos)) * sfm_wide_t'(`SFM_WIN_PER_S);
    assign vlActScaled = sfm_wide_t'(q.vl) * sfm_wide_t'(DET_RES);
    assign overActVel = actScaled > vlActScaled;

    assign commScaled = sfm_wide_t'(absDiff(posCount, q.commStart))
        * sfm_wide_t'(`SFM_DEG_PER_REV);
    assign commLimScaled = sfm_wide_t'(`SFM_COMM_DEG) * sfm_wide_t'(DET_RES);
    assign overComm = commScaled > commLimScaled;

    // ============================================================
    // Next state
    logic [24:0] divTrial;
    logic cmdEvt, limEvt, fbEvt, anyEvt, clearReq;
    logic [1:0] evtCause;

    assign divTrial = {q.divRem[23:0], q.divQuo[31]};
    assign cmdEvt = cmdRate.tick && overCmdMax;
    assign limEvt = cmdRate.tick && overCmdLim && (q.holdCnt >= 4'(`SFM_HOLD_WIN));
    assign fbEvt = fbRate.tick && (overFbTol || overActVel);
    assign anyEvt = cmdEvt || limEvt || fbEvt;
    assign clearReq = alarmClearInput || clearAlarmCommand;
    // Lowest sub-code wins when causes coincide
    assign evtCause = cmdEvt ? `SFM_SUB_CMD : (limEvt ? `SFM_SUB_LIM : `SFM_SUB_FB);

    always_comb begin
        d = q;
        d.histValid = 1'b0;

        // ============================================================
        // Commutation check, once per power cycle
        case (q.comm)
            CM_ARMED: begin
                if (servoOn) begin
                    d.comm = CM_CHECK;
                    d.commStart = posCount;
                    d.commCnt = 32'h0000_0000;
                end
            end
            CM_CHECK: begin
                // Motion after the servo drops is not charged to the drive
                if (overComm && servoOn) begin
                    d.commAlarm = 1'b1;
                end
                // Servo drop ends the check as well, so it never re-arms
                if (!servoOn || (q.commCnt >= 32'(COMM_CHECK_CYC - 1))) begin
                    d.comm = CM_DONE;
                end else begin
                    d.commCnt = q.commCnt + 32'h0000_0001;
                end
            end
            CM_DONE: begin
                d.comm = CM_DONE;
            end
            default: begin
                d.comm = CM_DONE;
            end
        endcase

        // ============================================================
        // Actual speed sampled once per feedback window
        if (fbRate.tick) begin
            d.prevPos = posCount;
        end

        // ============================================================
        // Limiter = highest feedback rate / feedback resolution
        if (feedbackResolutionWrite) begin
            d.frHeld = feedbackResolution;
            d.divBusy = 1'b1;
            d.divCnt = `SFM_DIV_STEPS;
            d.divRem = 25'h0000000;
            d.divQuo = 32'(FB_MAX_HZ);
        end else if (q.divBusy) begin
            if (divTrial >= {1'b0, q.frHeld}) begin
                d.divRem = divTrial - {1'b0, q.frHeld};
                d.divQuo = {q.divQuo[30:0], 1'b1};
            end else begin
                d.divRem = divTrial;
                d.divQuo = {q.divQuo[30:0], 1'b0};
            end
            d.divCnt = q.divCnt - 6'h01;
            if (q.divCnt == 6'h01) begin
                d.divBusy = 1'b0;
                // Saturate; zero resolution also lands here
                if ((q.frHeld == 24'h000000) || (d.divQuo[31:16] != 16'h0000)) begin
                    d.vl = 16'hFFFF;
                end else begin
                    d.vl = d.divQuo[15:0];
                end
            end
        end

        // ============================================================
        // Windows in a row above 1.5x limiter
        if (cmdRate.tick) begin
            if (!overCmdLim) begin
                d.holdCnt = 4'h0;
            end else if (q.holdCnt < 4'(`SFM_HOLD_WIN)) begin
                d.holdCnt = q.holdCnt + 4'h1;
            end
        end

        // ============================================================
        // Warning: a new event wins over a clear in the same cycle
        // A repeat of the standing cause is not logged, so history never floods
        if (clearReq) begin
            d.warn = 1'b0;
        end
        if (anyEvt) begin
            d.warn = 1'b1;
            d.cause = evtCause;
            if (!q.warn || (q.cause != evtCause)) begin
                d.hist[q.histPtr] = evtCause;
                d.histPtr = q.histPtr + 3'h1;
                if (q.histFill != 4'(`SFM_HIST_DEPTH)) begin
                    d.histFill = q.histFill + 4'h1;
                end
            end
        end

        // ============================================================
        // History query: index 0 is the newest entry
        if (alarmHistoryQuery) begin
            d.histValid = 1'b1;
            d.histHit = {1'b0, historyIndex} < q.histFill;
            d.histOut = q.hist[q.histPtr - 3'h1 - historyIndex];
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            q <= '0;
            q.comm <= CM_ARMED;
            q.vl <= `SFM_VL_RST;
        end else begin
            q <= d;
        end
    end

    // ============================================================
    // Outputs
    assign commutationAlarm = q.commAlarm;
    assign commandFeedbackWarning = q.warn;
    assign warningCause = q.cause;
    assign velocityLimiter = q.vl;
    assign velocityLimiterBusy = q.divBusy;
    assign historyCause = q.histOut;
    assign historyHit = q.histHit;
    assign historyValid = q.histValid;
endmodule // servo_fault_monitor
`default_nettype wire

/* File: sfm_check_monitor.sv */
// Concurrent checks on the servo fault monitor top-level ports.
// Assumes everything in the ref_clk domain; bound below the module.
`timescale 1ns/1ps
`default_nettype none
module sfm_check_monitor (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic servoOn,
    input wire logic alarmClearInput,
    input wire logic clearAlarmCommand,
    input wire logic alarmHistoryQuery,
    input wire logic feedbackResolutionWrite,
    input wire logic cpuHeartbeat,
    input wire logic commutationAlarm,
    input wire logic commandFeedbackWarning,
    input wire logic [1:0] warningCause,
    input wire logic [15:0] velocityLimiter,
    input wire logic velocityLimiterBusy,
    input wire logic historyValid,
    input wire logic processorFaultAlarm
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ==========
    // Assertions
    AST_LIM_BUSY: assert property (feedbackResolutionWrite |=> velocityLimiterBusy)
        else $error("limiter busy missing after write");
    AST_LIM_HOLD: assert property ($rose(velocityLimiterBusy) |-> velocityLimiterBusy[*8])
        else $error("limiter busy too short");
    AST_LIM_STABLE: assert property (!velocityLimiterBusy && !$past(velocityLimiterBusy)
        |-> $stable(velocityLimiter))
        else $error("limiter changed without recompute");
    AST_WARN_CLEAR: assert property ($fell(commandFeedbackWarning)
        |-> $past(alarmClearInput || clearAlarmCommand))
        else $error("warning dropped without clear");
    AST_WARN_HOLD: assert property (commandFeedbackWarning && !alarmClearInput
        && !clearAlarmCommand |=> commandFeedbackWarning)
        else $error("warning dropped early");
    AST_WARN_CAUSE: assert property (commandFeedbackWarning |-> warningCause != 2'h3)
        else $error("illegal warning cause");
    AST_COMM_STICKY: assert property (commutationAlarm |=> commutationAlarm)
        else $error("commutation alarm dropped");
    AST_COMM_CAUSE: assert property ($rose(commutationAlarm) |-> $past(servoOn))
        else $error("commutation alarm without servo on");
    AST_HIST_VALID: assert property (alarmHistoryQuery |=> historyValid ##1 !historyValid
        || alarmHistoryQuery)
        else $error("history answer not one cycle");
    AST_CPU_CAUSE: assert property ($rose(processorFaultAlarm)
        |-> $past(cpuHeartbeat, 2) == $past(cpuHeartbeat, 20))
        else $error("processor fault with live heartbeat");
    AST_CPU_STICKY: assert property (processorFaultAlarm |=> processorFaultAlarm)
        else $error("processor fault dropped");
endmodule // sfm_check_monitor
bind servo_fault_monitor sfm_check_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b),
    .servoOn(servoOn), .alarmClearInput(alarmClearInput), .cpuHeartbeat(cpuHeartbeat),
    .clearAlarmCommand(clearAlarmCommand), .alarmHistoryQuery(alarmHistoryQuery),
    .feedbackResolutionWrite(feedbackResolutionWrite), .commutationAlarm(commutationAlarm),
    .commandFeedbackWarning(commandFeedbackWarning), .warningCause(warningCause),
    .velocityLimiter(velocityLimiter), .velocityLimiterBusy(velocityLimiterBusy),
    .historyValid(historyValid), .processorFaultAlarm(processorFaultAlarm));
`default_nettype wire

/* File: sfm_host_model.sv */
// Model of the pulse-train master and the control processor beat.
// Assumes the bench gates it; changes outputs on falling edges only.
`timescale 1ns/1ps
`default_nettype none
module sfm_host_model (
    input wire logic clk,
    input wire logic pulseRun,
    input wire logic beatRun,
    output logic cmdPulse,
    output logic cpuHeartbeat
);
    int beatCnt = 0;
    initial begin
        cmdPulse = 1'b0;
        cpuHeartbeat = 1'b0;
    end
    // Pulses every other cycle so each one is a separate strobe
    always @(negedge clk) begin
        cmdPulse <= pulseRun && !cmdPulse;
        beatCnt <= (beatCnt == 9) ? 0 : beatCnt + 1;
        if (beatRun && beatCnt == 9) cpuHeartbeat <= !cpuHeartbeat;
    end
endmodule // sfm_host_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench of the servo fault monitor.
// Assumes short sim counts: 40-cycle windows, 50-cycle check, 100-cycle watchdog.
`timescale 1ns/1ps
`default_nettype none
module testbench import sfm_pkg::*;;
    typedef struct packed {logic [23:0] fr; logic [15:0] vl;} sfm_row_s;
    sfm_row_s rows [5] = '{'{24'h001388, 16'h0014}, '{24'h0186A0, 16'h0001},
        '{24'h000000, 16'hFFFF}, '{24'h000001, 16'hFFFF}, '{24'h004E20, 16'h0005}};
    logic ref_clk = 1'b0, rst_b = 1'b0, servoOn = 1'b0, pulseRun = 1'b0, beatRun = 1'b1;
    logic cmdPulse, cpuHeartbeat, fbw = 1'b0, aci = 1'b0, cac = 1'b0, ahq = 1'b0, fbp = 1'b0;
    logic [23:0] posCount = 24'h0, cr = 24'h002710, fr = 24'h0;
    logic [2:0] historyIndex = 3'h0;
    logic commAlarm, warn, busy, hVal, hHit, cpuFault;
    logic [1:0] cause, hCause;
    logic [15:0] vl;
    int mismatches = 0, num_checks = 0, cycles = 0;
    // Low feedback ceiling so a 40-cycle window can exceed its tolerance
    servo_fault_monitor #(.COMM_CHECK_CYC(50), .WDT_CYC(100), .WIN_CYC(40),
        .FB_MAX_HZ(100000)) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .servoOn(servoOn), .posCount(posCount),
        .cmdPulse(cmdPulse), .fbOutPulse(fbp), .circularResolution(cr),
        .feedbackResolution(fr), .feedbackResolutionWrite(fbw), .alarmClearInput(aci),
        .clearAlarmCommand(cac), .alarmHistoryQuery(ahq), .historyIndex(historyIndex),
        .cpuHeartbeat(cpuHeartbeat), .commutationAlarm(commAlarm),
        .commandFeedbackWarning(warn), .warningCause(cause), .velocityLimiter(vl),
        .velocityLimiterBusy(busy), .historyCause(hCause), .historyHit(hHit),
        .historyValid(hVal), .processorFaultAlarm(cpuFault));
    sfm_host_model u_host (.clk(ref_clk), .pulseRun(pulseRun), .beatRun(beatRun),
        .cmdPulse(cmdPulse), .cpuHeartbeat(cpuHeartbeat));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ==========
    // Helpers
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        cyc(6);
        rst_b = 1'b1;
        cyc(3);
    endtask
    task automatic clr();
        cac = 1'b1;
        cyc(1);
        cac = 1'b0;
        cyc(1);
    endtask
    task automatic query(input logic [2:0] idx, input logic [1:0] c, input logic hit);
        historyIndex = idx;
        ahq = 1'b1;
        cyc(1);
        ahq = 1'b0;
        chk(hVal, 1'b1);
        chk(hHit, hit);
        if (hit) chk(hCause, c);
        cyc(1);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, well above the roughly 1500 cycles the run needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            final_report();
        end
    end
    // ==========
    // Sequence
    initial begin
        do_reset();
        foreach (rows[i]) begin
            fr = rows[i].fr;
            fbw = 1'b1;
            cyc(1);
            fbw = 1'b0;
            cyc(1);
            chk(busy, 1'b1);
            cyc(32);
            chk(busy, 1'b0);
            chk(vl, rows[i].vl);
        end
        servoOn = 1'b1;
        cyc(5);
        posCount = 24'h0000AA;
        cyc(60);
        chk(commAlarm, 1'b0);
        posCount = 24'h000258;
        cyc(10);
        chk(commAlarm, 1'b0);
        cyc(100);
        chk(warn, 1'b1);
        chk(cause, 2'h2);
        query(3'h0, 2'h2, 1'b1);
        clr();
        chk(warn, 1'b0);
        servoOn = 1'b0;
        do_reset();
        chk({commAlarm, warn, busy, cpuFault, vl}, 20'h0000A);
        servoOn = 1'b1;
        cyc(5);
        posCount = 24'h000303;
        cyc(10);
        chk(commAlarm, 1'b1);
        cyc(100);
        clr();
        chk({commAlarm, warn}, 2'h2);
        cr = 24'h001388;
        pulseRun = 1'b1;
        cyc(100);
        pulseRun = 1'b0;
        chk(warn, 1'b1);
        chk(cause, 2'h0);
        cyc(80);
        aci = 1'b1;
        cyc(2);
        aci = 1'b0;
        cyc(1);
        chk(warn, 1'b0);
        cr = 24'h002710;
        pulseRun = 1'b1;
        cyc(320);
        chk(warn, 1'b0);
        cyc(280);
        pulseRun = 1'b0;
        chk(warn, 1'b1);
        chk(cause, 2'h1);
        query(3'h0, 2'h1, 1'b1);
        query(3'h1, 2'h0, 1'b1);
        query(3'h2, 2'h2, 1'b1);
        query(3'h5, 2'h0, 1'b0);
        clr();
        chk(warn, 1'b0);
        repeat (50) begin
            fbp = 1'b1;
            cyc(1);
            fbp = 1'b0;
            cyc(1);
        end
        chk(warn, 1'b1);
        chk(cause, 2'h2);
        query(3'h0, 2'h2, 1'b1);
        query(3'h1, 2'h1, 1'b1);
        chk(cpuFault, 1'b0);
        beatRun = 1'b0;
        cyc(130);
        chk(cpuFault, 1'b1);
        final_report();
    end
endmodule // testbench
`default_nettype wire
